/* core/rci_reset_irq.v */
/*
 * Reset-cause status flags and interrupt control for a small 8-bit core.
 * Assumes the instruction sequencer gives one-cycle instruction strobes,
 * and that power-on, reset-pin and watchdog inputs are synchronous.
 */
`timescale 1ns/100ps
`include "rci_map.vh"
module rci_reset_irq
#(
    parameter PORT_W = `RCI_PORT_WIDTH,
    parameter PC_W   = `RCI_PC_WIDTH
)
(
    input  wire              clock,
    input  wire              srst,
    input  wire              power_on,
    input  wire              reset_pin_disable,
    input  wire              reset_pin_n,
    input  wire              watchdog_timeout,
    input  wire              watchdog_clear_instr,
    input  wire              sleep_instr,
    input  wire              enable_interrupts_instr,
    input  wire              disable_interrupts_instr,
    input  wire              return_from_isr_instr,
    input  wire              soft_interrupt_instr,
    input  wire              timer_overflow,
    input  wire [PORT_W-1:0] port6_in,
    input  wire [PORT_W-1:0] port6_dir_input,
    input  wire              port6_read,
    input  wire              ext_int_select,
    input  wire [2:0]        flag_clear,
    input  wire [2:0]        flag_set,
    input  wire              flag_write,
    input  wire [2:0]        flag_wdata,
    input  wire              mask_write,
    input  wire [2:0]        mask_wdata,
    input  wire [PC_W-1:0]   return_pc,
    output wire              core_reset,
    output wire              port6_bit3_gpio,
    output reg               change_wake_q,
    output reg               timeout_q,
    output reg               power_down_q,
    output reg  [2:0]        cause_q,
    output reg  [2:0]        interrupt_flag_register,
    output reg  [2:0]        interrupt_mask_register,
    output reg               global_enable_q,
    output reg               sleeping_q,
    output wire              wake_up,
    output reg               vector_load_q,
    output reg  [PC_W-1:0]   vector_addr_q,
    output reg               push_q,
    output reg  [PC_W-1:0]   push_addr_q
);

    reg              pin_prev_q;
    reg              pin_rst_q;
    reg              wdog_rst_q;
    reg              change_wake_d;
    reg              timeout_d;
    reg              power_down_d;
    reg  [2:0]       cause_d;
    reg  [PORT_W-1:0] port_ref_q;
    wire [PORT_W-1:0] change_sel;
    wire             pin_low;
    wire             pin_rise;
    wire             port_change;
    wire [1:0]       falls;
    wire [2:0]       events;
    wire [2:0]       pending;
    wire             wake_change;
    wire             hw_take;
    wire             sw_take;

    // Pin is ignored when the option makes it a port bit
    assign pin_low         = ~reset_pin_disable & ~reset_pin_n;
    assign port6_bit3_gpio = reset_pin_disable;

    // Reset ends on the rising half of the high-low-high pulse
    assign pin_rise   = pin_prev_q & ~pin_low;
    assign core_reset = power_on | pin_low | watchdog_timeout;

    // Track pin level and hold reset pulses for the cause logic
    always @(posedge clock)
    begin
        if (srst | power_on)
        begin
            pin_prev_q <= 1'b0;
            pin_rst_q  <= 1'b0;
            wdog_rst_q <= 1'b0;
        end
        else
        begin
            pin_prev_q <= pin_low;
            pin_rst_q  <= pin_rise;
            wdog_rst_q <= watchdog_timeout;
        end
    end

    // Change detection on input-direction bits; the external pin counts only while ext_int_select is low
    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi = gi + 1)
        begin : g_chg
            if (gi == `RCI_EXT_PIN)
            begin : g_ext
                assign change_sel[gi] = port6_dir_input[gi] & ~ext_int_select
                                      & (port6_in[gi] ^ port_ref_q[gi]);
            end
            else
            begin : g_io
                assign change_sel[gi] = port6_dir_input[gi]
                                      & (port6_in[gi] ^ port_ref_q[gi]);
            end
        end
    endgenerate
    assign port_change = |change_sel;

    // Reference follows reads; software must read before enabling
    always @(posedge clock)
    begin
        if (srst)
            port_ref_q <= {PORT_W{1'b1}};
        else if (port6_read)
            port_ref_q <= port6_in;
    end

    // Rising edge of timer overflow line and falling edge of external pin
    rci_edge_detect
    #(
        .WIDTH (2)
    )
    u_fall
    (
        .clock      (clock),
        .srst       (srst),
        .level_in   ({~ext_int_select | port6_in[`RCI_EXT_PIN], ~timer_overflow}),
        .fall_pulse (falls)
    );

    // Timer event is the rising edge of the overflow strobe
    assign events[`RCI_BIT_TIMER]  = falls[0];
    assign events[`RCI_BIT_CHANGE] = port_change;
    assign events[`RCI_BIT_EXT]    = falls[1];

    // Change wakes only while sleeping and while its mask bit is set
    assign wake_change = sleeping_q & port_change
                       & interrupt_mask_register[`RCI_BIT_CHANGE];
    assign wake_up     = wake_change;

    // Status flags per reset cause and instruction
    always @*
    begin
        change_wake_d = change_wake_q;
        timeout_d     = timeout_q;
        power_down_d  = power_down_q;
        cause_d       = cause_q;
        if (pin_rst_q)
        begin
            change_wake_d = 1'b0;
            cause_d       = `RCI_CAUSE_PIN;
            if (sleeping_q)
            begin
                timeout_d    = 1'b1;
                power_down_d = 1'b0;
            end
        end
        else if (wdog_rst_q)
        begin
            change_wake_d = 1'b0;
            timeout_d     = 1'b0;
            cause_d       = `RCI_CAUSE_WDOG;
            if (sleeping_q)
                power_down_d = 1'b0;
        end
        else if (wake_change)
        begin
            change_wake_d = 1'b1;
            timeout_d     = 1'b1;
            power_down_d  = 1'b0;
            cause_d       = `RCI_CAUSE_WAKE;
        end
        else if (watchdog_clear_instr)
        begin
            timeout_d    = 1'b1;
            power_down_d = 1'b1;
        end
        else if (sleep_instr)
        begin
            timeout_d    = 1'b1;
            power_down_d = 1'b0;
        end
    end

    // Power-on forces the fresh state over everything else
    always @(posedge clock)
    begin
        if (srst | power_on)
        begin
            change_wake_q <= 1'b0;
            timeout_q     <= 1'b1;
            power_down_q  <= 1'b1;
            cause_q       <= `RCI_CAUSE_POWER;
        end
        else
        begin
            change_wake_q <= change_wake_d;
            timeout_q     <= timeout_d;
            power_down_q  <= power_down_d;
            cause_q       <= cause_d;
        end
    end

    // Sleep state: entered by instruction, left by any wake or reset
    always @(posedge clock)
    begin
        if (srst | power_on)
            sleeping_q <= 1'b0;
        else if (pin_rst_q | wdog_rst_q | wake_change)
            sleeping_q <= 1'b0;
        else if (sleep_instr)
            sleeping_q <= 1'b1;
    end

    // Flags; a set in the same cycle as a clear wins so no event is lost
    always @(posedge clock)
    begin
        if (srst | core_reset)
            interrupt_flag_register <= `RCI_FLAGS_RST;
        else if (flag_write)
            interrupt_flag_register <= flag_wdata | events | flag_set;
        else
            interrupt_flag_register <= (interrupt_flag_register & ~flag_clear)
                                     | events | flag_set;
    end

    // Mask register written by the core
    always @(posedge clock)
    begin
        if (srst | core_reset)
            interrupt_mask_register <= `RCI_MASK_RST;
        else if (mask_write)
            interrupt_mask_register <= mask_wdata;
    end

    assign pending = interrupt_flag_register & interrupt_mask_register;

    // Not taken while asleep; wake resumes first, then the branch follows
    assign hw_take = global_enable_q & (|pending) & ~sleeping_q;
    assign sw_take = global_enable_q & soft_interrupt_instr & ~hw_take;

    // Global enable; vectoring clears it so the routine is not re-entered
    always @(posedge clock)
    begin
        if (srst | core_reset)
            global_enable_q <= 1'b0;
        else if (hw_take | sw_take)
            global_enable_q <= 1'b0;
        else if (enable_interrupts_instr | return_from_isr_instr)
            global_enable_q <= 1'b1;
        else if (disable_interrupts_instr)
            global_enable_q <= 1'b0;
    end

    // Branch request to the sequencer, with return address push
    always @(posedge clock)
    begin
        if (srst | core_reset)
        begin
            vector_load_q <= 1'b0;
            vector_addr_q <= {PC_W{1'b0}};
            push_q        <= 1'b0;
            push_addr_q   <= {PC_W{1'b0}};
        end
        else
        begin
            vector_load_q <= hw_take | sw_take;
            push_q        <= hw_take | sw_take;
            if (hw_take | sw_take)
                push_addr_q <= return_pc;
            if (hw_take)
                vector_addr_q <= `RCI_HW_VECTOR;
            else if (sw_take)
                vector_addr_q <= `RCI_SW_VECTOR;
        end
    end

endmodule

/* core/rci_map.vh */
/*
 * Constants for the reset-cause and interrupt logic: flag bit positions,
 * reset values and branch addresses.
 * Assumes inclusion by bare name from core design files.
 */
`ifndef RCI_MAP_VH
`define RCI_MAP_VH

// Interrupt flag and mask bit positions
`define RCI_BIT_TIMER       0
`define RCI_BIT_CHANGE      1
`define RCI_BIT_EXT         2
`define RCI_NUM_IRQ         3

// Reset values
`define RCI_FLAGS_RST       3'h0
`define RCI_MASK_RST        3'h0

// Branch addresses
`define RCI_HW_VECTOR       10'h008
`define RCI_SW_VECTOR       10'h001
`define RCI_PC_WIDTH        10

// Port six layout
`define RCI_PORT_WIDTH      8
`define RCI_EXT_PIN         0
`define RCI_RESET_PIN       3

// Reset cause codes
`define RCI_CAUSE_NONE      3'h0
`define RCI_CAUSE_POWER     3'h1
`define RCI_CAUSE_PIN       3'h2
`define RCI_CAUSE_WDOG      3'h3
`define RCI_CAUSE_WAKE      3'h4

`endif

/* core/rci_edge_detect.v */
/*
 * Falling-edge detector for a vector of synchronous inputs.
 * Assumes inputs already synchronous to clock.
 */
`timescale 1ns/100ps
module rci_edge_detect
#(
    parameter WIDTH = 1
)
(
    input  wire             clock,
    input  wire             srst,
    input  wire [WIDTH-1:0] level_in,
    output wire [WIDTH-1:0] fall_pulse
);

    reg [WIDTH-1:0] prev_q;

    // Previous level; resets high so a low input at release counts as an edge
    always @(posedge clock)
    begin
        if (srst)
            prev_q <= {WIDTH{1'b1}};
        else
            prev_q <= level_in;
    end

    assign fall_pulse = prev_q & ~level_in;

endmodule

/* tb/rci_core_model.sv */
/*
 * Stand-in for the core sequencer: a program counter that follows vector loads.
 * Assumes one-cycle vector_load_q pulses from the reset and interrupt block.
 */
`timescale 1ns/100ps
module rci_core_model
(
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       vector_load_q,
    input  wire logic [9:0] vector_addr_q,
    output logic      [9:0] return_pc
);
    // Jump on a vector, else step; the count is the address to push
    always @(posedge clock)
        return_pc <= srst ? 10'h0 :
            (vector_load_q ? vector_addr_q : return_pc + 10'h1);
endmodule

/* tb/rci_reset_irq_sva.sv */
/*
 * Port checker for the reset-cause and interrupt block.
 * Assumes a bind to rci_reset_irq and a single clock domain.
 */
`timescale 1ns/100ps
module rci_reset_irq_sva
(
    input wire logic       clock,
    input wire logic       srst,
    input wire logic       power_on,
    input wire logic       reset_pin_disable,
    input wire logic       reset_pin_n,
    input wire logic       watchdog_timeout,
    input wire logic       watchdog_clear_instr,
    input wire logic       sleep_instr,
    input wire logic       timer_overflow,
    input wire logic       core_reset,
    input wire logic       port6_bit3_gpio,
    input wire logic       change_wake_q,
    input wire logic       timeout_q,
    input wire logic       power_down_q,
    input wire logic [2:0] interrupt_flag_register,
    input wire logic [2:0] interrupt_mask_register,
    input wire logic       global_enable_q,
    input wire logic       sleeping_q,
    input wire logic       wake_up,
    input wire logic       vector_load_q,
    input wire logic [9:0] vector_addr_q,
    input wire logic       push_q
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (srst);

    // Status flags after power-on, watchdog clear, sleep and change wake; reset pin option
    por_status_a: assert property (
        power_on |=> timeout_q && power_down_q && !change_wake_q)
        else $error("power-on status wrong");
    wdc_status_a: assert property (
        watchdog_clear_instr && !core_reset |=> timeout_q && power_down_q)
        else $error("watchdog clear status wrong");
    sleep_status_a: assert property (
        sleep_instr && !sleeping_q && !core_reset |=> sleeping_q && timeout_q && !power_down_q)
        else $error("sleep status wrong");
    // Pin edges excluded: a pin release also wakes, with other flags
    change_wake_a: assert property (
        sleeping_q && wake_up && !core_reset && $stable(reset_pin_n) && $past(reset_pin_n, 2)
        |=> !sleeping_q && change_wake_q && timeout_q && !power_down_q)
        else $error("change wake status wrong");
    pin_option_a: assert property (
        port6_bit3_gpio == reset_pin_disable && (reset_pin_disable || reset_pin_n || core_reset))
        else $error("reset pin option wrong");
    // Interrupt side
    timer_flag_a: assert property (
        $rose(timer_overflow) && !core_reset |=> interrupt_flag_register[0])
        else $error("timer flag not set");
    hw_vector_a: assert property (
        global_enable_q && !sleeping_q && !core_reset
        && |(interrupt_flag_register & interrupt_mask_register)
        |=> vector_load_q && vector_addr_q == 10'h008)
        else $error("hardware vector missing");
    vector_push_a: assert property (
        vector_load_q |-> push_q && !global_enable_q)
        else $error("vector without push or with enable");
endmodule

/* tb/tb.sv */
/*
 * Directed testbench for the reset-cause and interrupt block.
 * Assumes the core model as far side and the checker bound below.
 */
`timescale 1ns/100ps
module tb;
    logic       clock = 1'b0;
    logic       srst = 1'b1;
    logic       power_on = 1'b0, reset_pin_disable = 1'b0, reset_pin_n = 1'b1;
    logic       watchdog_timeout = 1'b0, timer_overflow = 1'b0, port6_read = 1'b0;
    logic       ext_int_select = 1'b0, mask_write = 1'b0;
    logic [5:0] ins = 6'h0;
    logic [2:0] flag_clear = 3'h0, mask_wdata = 3'h0, cause_q, flags;
    logic [7:0] port6_in = 8'hff, port6_dir_input = 8'hff;
    logic [9:0] return_pc, vector_addr_q;
    logic       core_reset, port6_bit3_gpio, change_wake_q, timeout_q, power_down_q;
    logic       global_enable_q, sleeping_q, vector_load_q;
    int         fail_count = 0, samples_checked = 0;

    rci_reset_irq dut
    (
        .clock(clock), .srst(srst), .power_on(power_on),
        .reset_pin_disable(reset_pin_disable), .reset_pin_n(reset_pin_n),
        .watchdog_timeout(watchdog_timeout), .watchdog_clear_instr(ins[0]),
        .sleep_instr(ins[1]), .enable_interrupts_instr(ins[2]),
        .disable_interrupts_instr(ins[3]), .return_from_isr_instr(ins[4]),
        .soft_interrupt_instr(ins[5]), .timer_overflow(timer_overflow),
        .port6_in(port6_in), .port6_dir_input(port6_dir_input), .port6_read(port6_read),
        .ext_int_select(ext_int_select), .flag_clear(flag_clear), .flag_set(3'h0),
        .flag_write(1'b0), .flag_wdata(3'h0), .mask_write(mask_write),
        .mask_wdata(mask_wdata), .return_pc(return_pc), .core_reset(core_reset),
        .port6_bit3_gpio(port6_bit3_gpio), .change_wake_q(change_wake_q),
        .timeout_q(timeout_q), .power_down_q(power_down_q), .cause_q(cause_q),
        .interrupt_flag_register(flags), .interrupt_mask_register(),
        .global_enable_q(global_enable_q), .sleeping_q(sleeping_q), .wake_up(),
        .vector_load_q(vector_load_q), .vector_addr_q(vector_addr_q), .push_q(),
        .push_addr_q()
    );

    rci_core_model u_core
    (
        .clock(clock), .srst(srst), .vector_load_q(vector_load_q),
        .vector_addr_q(vector_addr_q), .return_pc(return_pc)
    );

    // Free-running 100 MHz clock
    initial
        forever #5 clock = ~clock;

    // Inputs move 1 ns after the edge, clear of sampling
    task cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
            fail_count++;
        end
    endtask

    task stop_test;
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Strobe bits: 0 wdc, 1 sleep, 2 enable, 3 disable, 4 return, 5 soft
    task op(input int k);
        ins = 6'h1 << k;
        cyc(1);
        ins = 6'h0;
    endtask

    task chk_st(input logic [2:0] st, input logic [2:0] cs);
        check("status", {7'h0, change_wake_q, timeout_q, power_down_q}, {7'h0, st});
        check("cause", {7'h0, cause_q}, {7'h0, cs});
    endtask

    // Pin low two cycles; status lands two edges after release
    task pin;
        reset_pin_n = 1'b0;
        cyc(2);
        reset_pin_n = 1'b1;
        cyc(2);
    endtask

    task wdog;
        watchdog_timeout = 1'b1;
        cyc(1);
        watchdog_timeout = 1'b0;
        cyc(1);
    endtask

    task mask(input logic [2:0] v);
        mask_write = 1'b1;
        mask_wdata = v;
        cyc(1);
        mask_write = 1'b0;
    endtask

    // Bounded wait for a vector pulse, then its address
    task wait_vec(input logic [9:0] a);
        int i;
        i = 0;
        while (vector_load_q !== 1'b1 && i < 6)
        begin
            cyc(1);
            i++;
        end
        check("vec_load", {9'h0, vector_load_q}, 10'h1);
        check("vec_addr", vector_addr_q, a);
    endtask

    task t_status;
        power_on = 1'b1;
        cyc(1);
        power_on = 1'b0;
        cyc(1);
        chk_st(3'h3, 3'h1);
        op(0);
        chk_st(3'h3, 3'h1);
        wdog();
        chk_st(3'h1, 3'h3);
        pin();
        chk_st(3'h1, 3'h2);
        op(1);
        chk_st(3'h2, 3'h2);
        pin();
        chk_st(3'h2, 3'h2);
        check("sleeping", {9'h0, sleeping_q}, 10'h0);
        op(1);
        wdog();
        chk_st(3'h0, 3'h3);
        reset_pin_disable = 1'b1;
        reset_pin_n = 1'b0;
        cyc(2);
        check("core_reset", {9'h0, core_reset}, 10'h0);
        check("gpio", {9'h0, port6_bit3_gpio}, 10'h1);
        reset_pin_n = 1'b1;
        reset_pin_disable = 1'b0;
    endtask

    task t_irq;
        timer_overflow = 1'b1;
        cyc(1);
        timer_overflow = 1'b0;
        op(2);
        cyc(2);
        check("flags", {7'h0, flags}, 10'h1);
        check("vec_idle", {9'h0, vector_load_q}, 10'h0);
        check("enable", {9'h0, global_enable_q}, 10'h1);
        mask(3'h1);
        wait_vec(10'h008);
        check("enable", {9'h0, global_enable_q}, 10'h0);
        flag_clear = 3'h1;
        cyc(1);
        flag_clear = 3'h0;
        op(4);
        check("enable", {9'h0, global_enable_q}, 10'h1);
        op(3);
        check("enable", {9'h0, global_enable_q}, 10'h0);
        op(5);
        check("soft_off", {9'h0, vector_load_q}, 10'h0);
        op(2);
        op(5);
        wait_vec(10'h001);
    endtask

    task t_change;
        port6_read = 1'b1;
        cyc(1);
        port6_read = 1'b0;
        mask(3'h2);
        op(2);
        port6_dir_input = 8'hbf;
        op(1);
        port6_in[6] = 1'b0;
        cyc(3);
        check("sleeping", {9'h0, sleeping_q}, 10'h1);
        port6_in[5] = 1'b0;
        wait_vec(10'h008);
        chk_st(3'h6, 3'h4);
    endtask

    task t_ext;
        port6_in = 8'hff;
        port6_dir_input = 8'hff;
        srst = 1'b1;
        cyc(1);
        srst = 1'b0;
        ext_int_select = 1'b1;
        port6_in[0] = 1'b0;
        cyc(3);
        check("ext_flags", {8'h0, flags[2:1]}, 10'h2);
    endtask

    initial
    begin
        cyc(20);
        srst = 1'b0;
        t_status();
        t_irq();
        t_change();
        t_ext();
        stop_test();
    end

    // Whole run is under a hundred cycles
    initial
    begin
        #20000;
        fail_count++;
        stop_test();
    end
endmodule

bind rci_reset_irq rci_reset_irq_sva u_sva
(
    .clock(clock), .srst(srst), .power_on(power_on), .reset_pin_disable(reset_pin_disable),
    .reset_pin_n(reset_pin_n), .watchdog_timeout(watchdog_timeout),
    .watchdog_clear_instr(watchdog_clear_instr), .sleep_instr(sleep_instr),
    .timer_overflow(timer_overflow), .core_reset(core_reset),
    .port6_bit3_gpio(port6_bit3_gpio), .change_wake_q(change_wake_q),
    .timeout_q(timeout_q), .power_down_q(power_down_q),
    .interrupt_flag_register(interrupt_flag_register),
    .interrupt_mask_register(interrupt_mask_register), .global_enable_q(global_enable_q),
    .sleeping_q(sleeping_q), .wake_up(wake_up), .vector_load_q(vector_load_q),
    .vector_addr_q(vector_addr_q), .push_q(push_q)
);
